//--- pkg/mlts_regs.vh
/*
  Register map, field positions, reset values and encodings of the trace sequencer.
  Assumes a 32-bit APB slave with one aligned word per register.
*/
`ifndef MLTS_REGS_VH
`define MLTS_REGS_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define MLTS_OFS_CTRL 12'h000
`define MLTS_OFS_STAT 12'h004
`define MLTS_OFS_IRQ_STAT 12'h008
`define MLTS_OFS_IRQ_MASK 12'h00c
`define MLTS_OFS_PRE_QUAL 12'h010
`define MLTS_OFS_CNT_QUAL 12'h014
`define MLTS_OFS_COUNT 12'h018
`define MLTS_OFS_RD_IDX 12'h01c
`define MLTS_OFS_RD_DATA 12'h020
`define MLTS_OFS_RD_COUNT 12'h024
`define MLTS_OFS_PAT_BASE 12'h040
`define MLTS_OFS_RANGE_LO 12'h080
`define MLTS_OFS_RANGE_HI 12'h084
`define MLTS_OFS_LVL_BASE 12'h100

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define MLTS_CTRL_START 0
`define MLTS_CTRL_STOP 1
`define MLTS_CTRL_CONT 2
`define MLTS_CTRL_BRK 3
`define MLTS_CTRL_PLACE_LO 4
`define MLTS_CTRL_PLACE_HI 5
`define MLTS_CTRL_CMODE_LO 6
`define MLTS_CTRL_CMODE_HI 7
`define MLTS_CTRL_TLVL_LO 8
`define MLTS_CTRL_TLVL_HI 10

// ----------------------------------------------------------------------------
// Encodings
// ----------------------------------------------------------------------------
`define MLTS_PLACE_START 2'h0
`define MLTS_PLACE_CENTER 2'h1
`define MLTS_PLACE_END 2'h2
`define MLTS_CMODE_OFF 2'h0
`define MLTS_CMODE_TIME 2'h1
`define MLTS_CMODE_STATE 2'h2

// Condition word: pattern set 1, pattern set 2, range, not range, arm, ops.
`define MLTS_COND_S1_LO 0
`define MLTS_COND_S1_HI 7
`define MLTS_COND_S2_LO 8
`define MLTS_COND_S2_HI 15
`define MLTS_COND_RANGE 16
`define MLTS_COND_NRANGE 17
`define MLTS_COND_ARM 18
`define MLTS_COND_NOR1 19
`define MLTS_COND_NOR2 20
`define MLTS_COND_AND 21
`define MLTS_COND_ANY 22

// Level word slots: primary, secondary, store, targets.
`define MLTS_LVL_PRI 2'h0
`define MLTS_LVL_SEC 2'h1
`define MLTS_LVL_STO 2'h2
`define MLTS_LVL_TGT 2'h3
`define MLTS_TGT_PRI_LO 0
`define MLTS_TGT_PRI_HI 2
`define MLTS_TGT_SEC_LO 4
`define MLTS_TGT_SEC_HI 6

// Interrupt status bits.
`define MLTS_IRQ_TRIG 0
`define MLTS_IRQ_DONE 1
`define MLTS_IRQ_W 2

`define MLTS_RST_CTRL 32'h0000_0000
`define MLTS_CTRL_KEEP 32'h0000_07fc
`define MLTS_LEVEL1 3'h0

`endif

//--- hw/mlts_cond.v
/*
  Evaluates one trace condition from eight pattern hits, range hit and arm.
  Assumes the pattern hits come from logic on the same clock as the caller.
*/
`timescale 1ns/1ps
`include "mlts_regs.vh"

module mlts_cond (
  input wire [31:0] cond,
  input wire [7:0] pat_hit,
  input wire range_hit,
  input wire arm,
  output wire match
);

  wire [7:0] s1_sel;
  wire [7:0] s2_sel;
  wire set1_or;
  wire set2_or;
  wire set1;
  wire set2;
  wire term1;

  assign s1_sel = cond[`MLTS_COND_S1_HI:`MLTS_COND_S1_LO];
  assign s2_sel = cond[`MLTS_COND_S2_HI:`MLTS_COND_S2_LO];
  // Set 1 also collects the range, not-range and arm terms.
  assign set1_or = (|(s1_sel & pat_hit)) | (cond[`MLTS_COND_RANGE] & range_hit) |
    (cond[`MLTS_COND_NRANGE] & ~range_hit) | (cond[`MLTS_COND_ARM] & arm);
  assign set2_or = |(s2_sel & pat_hit);
  assign set1 = cond[`MLTS_COND_NOR1] ? ~set1_or : set1_or;
  assign set2 = cond[`MLTS_COND_NOR2] ? ~set2_or : set2_or;
  assign term1 = cond[`MLTS_COND_AND] ? (set1 & set2) : (set1 | set2);
  assign match = cond[`MLTS_COND_ANY] | term1;

endmodule // mlts_cond

//--- hw/mlts_seq.v
/*
  Multilevel trace sequencer with capture buffer, APB register slave and interrupt.
  Assumes traced states arrive on the ref_clk domain with a one-cycle strobe,
  and the arm connector is an asynchronous pin.
*/
// The register offsets and the APB register port were left to the implementer.
// Overview of operation
// - A trace starts at level 1 and waits there for a branch match.
// - When both branches match, the primary target is taken.
// - A match moves to that branch's target level, then waits there.
// - Eight levels, each with primary, secondary, targets and store qualifier.
// - Outside continuous mode, entering the trigger level raises the trigger.
// - States meeting the active level's store qualifier are stored, and so is the trigger state.
// - Count mode selects every traced state, qualified occurrences or off.
// - Up to two prestore-qualified states precede each stored state.
// - Start placement puts the trigger first, then stores after it.
// - Centre placement puts the trigger in the buffer middle.
// - End placement puts the trigger last, keeping only earlier states.
// - With break enabled, the trigger requests a monitor break.
// - Continuous mode captures until a stop command.
// - A stop command ends any running capture.
// - The low 32 bits of stored states are readable as soon as capture stops.
// - Conditions combine eight patterns, range and arm with set operators.
// - The arm term follows the external arm input.
`timescale 1ns/1ps
`include "mlts_regs.vh"

module mlts_seq #(
  parameter AW = 24,
  parameter DW = 16,
  parameter SW = 8,
  parameter DEPTH_LOG2 = 8
) (
  input wire ref_clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire state_valid,
  input wire [AW-1:0] state_addr,
  input wire [DW-1:0] state_data,
  input wire [SW-1:0] state_stat,
  input wire arm_in,
  output reg trigger_r,
  output reg break_req_r,
  output wire irq
);

  localparam DEPTH = 1 << DEPTH_LOG2;
  localparam BW = AW + DW + SW;
  localparam [DEPTH_LOG2-1:0] HALF = {1'b1, {(DEPTH_LOG2-1){1'b0}}};
  localparam [DEPTH_LOG2-1:0] LAST = {DEPTH_LOG2{1'b1}};
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_RUN = 3'b010;
  localparam [2:0] ST_POST = 3'b100;

  // --------------------------------------------------------------------------
  // Configuration storage
  // --------------------------------------------------------------------------
  reg [31:0] ctrl_r;
  reg [31:0] pre_qual_r;
  reg [31:0] cnt_qual_r;
  reg [31:0] lvl_cfg_r [0:31];
  reg [AW-1:0] pat_addr_r [0:7];
  reg [AW-1:0] range_lo_r;
  reg [AW-1:0] range_hi_r;
  reg [BW-1:0] buf_mem [0:DEPTH-1];
  reg [`MLTS_IRQ_W-1:0] irq_stat_r;
  reg [`MLTS_IRQ_W-1:0] irq_mask_r;
  reg [2:0] st_r;
  reg [2:0] level_r;
  reg [DEPTH_LOG2-1:0] wr_ptr_r;
  reg [DEPTH_LOG2:0] fill_r;
  reg [DEPTH_LOG2-1:0] post_left_r;
  reg [DEPTH_LOG2-1:0] rd_idx_r;
  reg [31:0] count_r;
  reg [BW-1:0] pre0_r;
  reg [BW-1:0] pre1_r;
  reg [1:0] pre_n_r;
  reg [2:0] arm_sync_r;
  reg arm_r;
  reg [BW-1:0] rd_word_r;

  wire wr_en;
  wire [11:0] ofs;
  wire start_cmd;
  wire stop_cmd;
  wire [1:0] place;
  wire [1:0] cmode;
  wire [2:0] trig_lvl;
  wire [BW-1:0] cur_state;

  function is_ofs(input [11:0] a, input [11:0] b);
    is_ofs = (a == b);
  endfunction

  assign wr_en = psel & penable & pwrite;
  assign ofs = {paddr[11:2], 2'b00};
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign start_cmd = wr_en & is_ofs(ofs, `MLTS_OFS_CTRL) & pwdata[`MLTS_CTRL_START];
  assign stop_cmd = wr_en & is_ofs(ofs, `MLTS_OFS_CTRL) & pwdata[`MLTS_CTRL_STOP];
  assign place = ctrl_r[`MLTS_CTRL_PLACE_HI:`MLTS_CTRL_PLACE_LO];
  assign cmode = ctrl_r[`MLTS_CTRL_CMODE_HI:`MLTS_CTRL_CMODE_LO];
  assign trig_lvl = ctrl_r[`MLTS_CTRL_TLVL_HI:`MLTS_CTRL_TLVL_LO];
  assign cur_state = {state_addr, state_data, state_stat};

  // --------------------------------------------------------------------------
  // Arm input synchroniser
  // --------------------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      arm_sync_r <= 3'h0;
      arm_r <= 1'b0;
    end else begin
      arm_sync_r <= {arm_sync_r[1:0], arm_in};
      if (arm_sync_r[2] == arm_sync_r[1]) begin
        arm_r <= arm_sync_r[2];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Pattern and condition evaluation
  // --------------------------------------------------------------------------
  wire [7:0] pat_hit;
  wire range_hit;
  wire pri_hit;
  wire sec_hit;
  wire sto_hit;
  wire pre_hit;
  wire cnt_hit;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_pat
      assign pat_hit[gi] = (state_addr == pat_addr_r[gi]);
    end
  endgenerate

  assign range_hit = (state_addr >= range_lo_r) && (state_addr <= range_hi_r);

  // Level configuration: four words per level, indexed by level and slot.
  mlts_cond u_pri (.cond(lvl_cfg_r[{level_r, `MLTS_LVL_PRI}]), .pat_hit(pat_hit),
    .range_hit(range_hit), .arm(arm_r), .match(pri_hit));
  mlts_cond u_sec (.cond(lvl_cfg_r[{level_r, `MLTS_LVL_SEC}]), .pat_hit(pat_hit),
    .range_hit(range_hit), .arm(arm_r), .match(sec_hit));
  mlts_cond u_sto (.cond(lvl_cfg_r[{level_r, `MLTS_LVL_STO}]), .pat_hit(pat_hit),
    .range_hit(range_hit), .arm(arm_r), .match(sto_hit));
  mlts_cond u_pre (.cond(pre_qual_r), .pat_hit(pat_hit),
    .range_hit(range_hit), .arm(arm_r), .match(pre_hit));
  mlts_cond u_cnt (.cond(cnt_qual_r), .pat_hit(pat_hit),
    .range_hit(range_hit), .arm(arm_r), .match(cnt_hit));

  wire [31:0] tgt_word = lvl_cfg_r[{level_r, `MLTS_LVL_TGT}];
  reg [2:0] next_level;
  reg branch;

  always @* begin
    next_level = level_r;
    branch = 1'b0;
    if (pri_hit) begin
      next_level = tgt_word[`MLTS_TGT_PRI_HI:`MLTS_TGT_PRI_LO];
      branch = 1'b1;
    end else if (sec_hit) begin
      next_level = tgt_word[`MLTS_TGT_SEC_HI:`MLTS_TGT_SEC_LO];
      branch = 1'b1;
    end
  end

  // The trigger fires on a branch into the trigger level; the start at level 1 does not count.
  wire trig_now;
  wire running;
  wire stores;
  wire skip_pre = (place == `MLTS_PLACE_START) && !trigger_r && !ctrl_r[`MLTS_CTRL_CONT];
  assign running = (st_r == ST_RUN) || (st_r == ST_POST);
  assign trig_now = (st_r == ST_RUN) && state_valid && !trigger_r && branch &&
    (next_level == trig_lvl) && !ctrl_r[`MLTS_CTRL_CONT];
  // In start placement, outside continuous mode, nothing before the trigger is kept.
  assign stores = running && state_valid && (sto_hit || trig_now) &&
    !(skip_pre && !trig_now);

  // --------------------------------------------------------------------------
  // Sequencer and capture
  // --------------------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      st_r <= ST_IDLE;
      level_r <= `MLTS_LEVEL1;
      trigger_r <= 1'b0;
      break_req_r <= 1'b0;
      wr_ptr_r <= {DEPTH_LOG2{1'b0}};
      fill_r <= {(DEPTH_LOG2+1){1'b0}};
      post_left_r <= {DEPTH_LOG2{1'b0}};
      count_r <= 32'h0000_0000;
      pre_n_r <= 2'h0;
      pre0_r <= {BW{1'b0}};
      pre1_r <= {BW{1'b0}};
    end else begin
      break_req_r <= 1'b0;
      if (start_cmd) begin
        st_r <= ST_RUN;
        level_r <= `MLTS_LEVEL1;
        trigger_r <= 1'b0;
        wr_ptr_r <= {DEPTH_LOG2{1'b0}};
        fill_r <= {(DEPTH_LOG2+1){1'b0}};
        count_r <= 32'h0000_0000;
        pre_n_r <= 2'h0;
      end else if (stop_cmd) begin
        st_r <= ST_IDLE;
      end else if (running && state_valid) begin
        if (st_r == ST_RUN) begin
          level_r <= next_level;
        end
        if (cmode == `MLTS_CMODE_TIME || (cmode == `MLTS_CMODE_STATE && cnt_hit)) begin
          count_r <= count_r + 32'h0000_0001;
        end
        if (trig_now) begin
          trigger_r <= 1'b1;
          break_req_r <= ctrl_r[`MLTS_CTRL_BRK];
          case (place)
            `MLTS_PLACE_START: begin
              st_r <= ST_POST;
              post_left_r <= LAST;
            end
            `MLTS_PLACE_CENTER: begin
              st_r <= ST_POST;
              post_left_r <= HALF - 1'b1;
            end
            default: begin
              st_r <= ST_IDLE;
            end
          endcase
        end
        if (stores) begin
          if (pre_n_r == 2'h2) begin
            buf_mem[wr_ptr_r] <= pre1_r;
          end
          if (pre_n_r != 2'h0) begin
            buf_mem[wr_ptr_r + pre_n_r - 1'b1] <= pre0_r;
          end
          buf_mem[wr_ptr_r + pre_n_r] <= cur_state;
          wr_ptr_r <= wr_ptr_r + {{(DEPTH_LOG2-2){1'b0}}, pre_n_r} + 1'b1;
          if (fill_r + pre_n_r + 1'b1 > DEPTH) begin
            fill_r <= DEPTH[DEPTH_LOG2:0];
          end else begin
            fill_r <= fill_r + pre_n_r + 1'b1;
          end
          pre_n_r <= 2'h0;
          if (st_r == ST_POST && !trig_now) begin
            if (post_left_r <= {{(DEPTH_LOG2-2){1'b0}}, pre_n_r} + 1'b1) begin
              st_r <= ST_IDLE;
            end else begin
              post_left_r <= post_left_r - pre_n_r - 1'b1;
            end
          end
        end else if (pre_hit && !skip_pre) begin
          pre1_r <= pre0_r;
          pre0_r <= cur_state;
          if (pre_n_r != 2'h2) begin
            pre_n_r <= pre_n_r + 1'b1;
          end
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Buffer readout, oldest entry first
  // --------------------------------------------------------------------------
  wire [DEPTH_LOG2-1:0] oldest = (fill_r == DEPTH) ? wr_ptr_r : {DEPTH_LOG2{1'b0}};

  always @(posedge ref_clk) begin
    rd_word_r <= buf_mem[oldest + rd_idx_r];
  end

  // --------------------------------------------------------------------------
  // Register writes and interrupt
  // --------------------------------------------------------------------------
  wire ev_done;
  integer k;
  assign ev_done = running && (stop_cmd || (st_r == ST_RUN && trig_now &&
    place == `MLTS_PLACE_END));
  assign irq = |(irq_stat_r & irq_mask_r);

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl_r <= `MLTS_RST_CTRL;
      pre_qual_r <= 32'h0000_0000;
      cnt_qual_r <= 32'h0000_0000;
      irq_mask_r <= {`MLTS_IRQ_W{1'b0}};
      irq_stat_r <= {`MLTS_IRQ_W{1'b0}};
      rd_idx_r <= {DEPTH_LOG2{1'b0}};
      range_lo_r <= {AW{1'b0}};
      range_hi_r <= {AW{1'b0}};
      for (k = 0; k < 32; k = k + 1) begin
        lvl_cfg_r[k] <= 32'h0000_0000;
      end
      for (k = 0; k < 8; k = k + 1) begin
        pat_addr_r[k] <= {AW{1'b0}};
      end
    end else begin
      irq_stat_r[`MLTS_IRQ_TRIG] <= trig_now | (irq_stat_r[`MLTS_IRQ_TRIG] &
        ~(wr_en & is_ofs(ofs, `MLTS_OFS_IRQ_STAT) & pwdata[`MLTS_IRQ_TRIG]));
      irq_stat_r[`MLTS_IRQ_DONE] <= ev_done | (irq_stat_r[`MLTS_IRQ_DONE] &
        ~(wr_en & is_ofs(ofs, `MLTS_OFS_IRQ_STAT) & pwdata[`MLTS_IRQ_DONE]));
      if (wr_en) begin
        if (is_ofs(ofs, `MLTS_OFS_CTRL)) begin
          ctrl_r <= pwdata & `MLTS_CTRL_KEEP;
        end
        if (is_ofs(ofs, `MLTS_OFS_IRQ_MASK)) begin
          irq_mask_r <= pwdata[`MLTS_IRQ_W-1:0];
        end
        if (is_ofs(ofs, `MLTS_OFS_PRE_QUAL)) begin
          pre_qual_r <= pwdata;
        end
        if (is_ofs(ofs, `MLTS_OFS_CNT_QUAL)) begin
          cnt_qual_r <= pwdata;
        end
        if (is_ofs(ofs, `MLTS_OFS_RD_IDX)) begin
          rd_idx_r <= pwdata[DEPTH_LOG2-1:0];
        end
        if (is_ofs(ofs, `MLTS_OFS_RANGE_LO)) begin
          range_lo_r <= pwdata[AW-1:0];
        end
        if (is_ofs(ofs, `MLTS_OFS_RANGE_HI)) begin
          range_hi_r <= pwdata[AW-1:0];
        end
        if (ofs[11:5] == `MLTS_OFS_PAT_BASE >> 5) begin
          pat_addr_r[ofs[4:2]] <= pwdata[AW-1:0];
        end
        if (ofs[11:7] == `MLTS_OFS_LVL_BASE >> 7) begin
          lvl_cfg_r[ofs[6:2]] <= pwdata;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Register reads
  // --------------------------------------------------------------------------
  always @* begin
    prdata = 32'h0000_0000;
    if (ofs[11:7] == `MLTS_OFS_LVL_BASE >> 7) begin
      prdata = lvl_cfg_r[ofs[6:2]];
    end else if (ofs[11:5] == `MLTS_OFS_PAT_BASE >> 5) begin
      prdata[AW-1:0] = pat_addr_r[ofs[4:2]];
    end else begin
      case (ofs)
        `MLTS_OFS_CTRL: prdata = ctrl_r;
        `MLTS_OFS_STAT: prdata = {24'h000000, running, trigger_r, 3'h0, level_r};
        `MLTS_OFS_IRQ_STAT: prdata[`MLTS_IRQ_W-1:0] = irq_stat_r;
        `MLTS_OFS_IRQ_MASK: prdata[`MLTS_IRQ_W-1:0] = irq_mask_r;
        `MLTS_OFS_PRE_QUAL: prdata = pre_qual_r;
        `MLTS_OFS_CNT_QUAL: prdata = cnt_qual_r;
        `MLTS_OFS_COUNT: prdata = count_r;
        `MLTS_OFS_RD_IDX: prdata[DEPTH_LOG2-1:0] = rd_idx_r;
        `MLTS_OFS_RD_DATA: prdata = rd_word_r[31:0];
        `MLTS_OFS_RD_COUNT: prdata[DEPTH_LOG2:0] = fill_r;
        `MLTS_OFS_RANGE_LO: prdata[AW-1:0] = range_lo_r;
        `MLTS_OFS_RANGE_HI: prdata[AW-1:0] = range_hi_r;
        default: prdata = 32'h0000_0000;
      endcase
    end
  end

endmodule // mlts_seq

//--- tb/mlts_seq_monitor.sv
/*
  Concurrent checks on the ports of the trace sequencer.
  Assumes one clock domain and the synchronous active-low reset of the block.
*/
`timescale 1ns/1ps
module mlts_seq_monitor (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic state_valid,
  input wire logic trigger_r,
  input wire logic break_req_r,
  input wire logic irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  wire acc = psel && penable;
  wire start_hit = acc && pwrite && paddr[11:2] == 10'h000 && pwdata[0];

  // ----------------------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------------------
  sequence s_start;
    start_hit;
  endsequence
  sequence s_brk_one;
    $rose(trigger_r) ##1 !break_req_r;
  endsequence

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  chk_zero_wait: assert property (acc |-> pready && !pslverr)
    else $error("access not answered at once");
  chk_unmapped_rd: assert property (acc && !pwrite && paddr == 12'h028 |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  chk_trig_cause: assert property ($rose(trigger_r) |-> $past(state_valid))
    else $error("trigger without a traced state");
  chk_trig_holds: assert property (trigger_r && !start_hit |=> trigger_r)
    else $error("trigger dropped without start");
  chk_start_clears: assert property (s_start |=> !trigger_r)
    else $error("start left trigger set");
  chk_brk_pulse: assert property ($rose(break_req_r) |-> s_brk_one)
    else $error("break request not a one-cycle pulse at trigger");
  chk_brk_only_trig: assert property (break_req_r |-> trigger_r)
    else $error("break request without trigger");
  chk_irq_clear: assert property (acc && pwrite && paddr == 12'h008 && pwdata[1:0] == 2'h3
      && !state_valid |=> !irq)
    else $error("irq still high after clear");
  chk_mask_off: assert property (acc && pwrite && paddr == 12'h00c && pwdata[1:0] == 2'h0
      |=> !irq)
    else $error("irq high while masked");
  chk_rst_quiet: assert property (disable iff (1'b0) !rst_n |=> !trigger_r && !break_req_r
      && !irq)
    else $error("outputs active after reset");
endmodule // mlts_seq_monitor

bind mlts_seq mlts_seq_monitor mlts_seq_monitor_i (
  .ref_clk(ref_clk),
  .rst_n(rst_n),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .state_valid(state_valid),
  .trigger_r(trigger_r),
  .break_req_r(break_req_r),
  .irq(irq)
);

//--- tb/mlts_tgt_model.sv
/*
  Model of the traced target: emits bus states and drives the arm connector.
  Assumes the bench calls its tasks and the sequencer samples on ref_clk.
*/
`timescale 1ns/1ps
module mlts_tgt_model (
  input wire logic ref_clk,
  input wire logic break_req_r,
  output logic state_valid,
  output logic [23:0] state_addr,
  output logic [15:0] state_data,
  output logic [7:0] state_stat,
  output logic arm_in
);
  int brk_seen = 0;

  initial begin
    state_valid = 1'b0;
    state_addr = 24'h000000;
    state_data = 16'h0000;
    state_stat = 8'h00;
    arm_in = 1'b0;
  end

  // Counts monitor break requests taken by the target.
  always @(posedge ref_clk) begin
    if (break_req_r === 1'b1) begin
      brk_seen <= brk_seen + 1;
    end
  end

  // Lines outside a strobe carry the inverse so stale values never match.
  task automatic emit(input logic [23:0] a, input logic [15:0] d, input int gap);
    @(posedge ref_clk);
    state_valid <= 1'b1;
    state_addr <= a;
    state_data <= d;
    state_stat <= 8'h5a;
    @(posedge ref_clk);
    state_valid <= 1'b0;
    state_addr <= ~a;
    state_data <= ~d;
    state_stat <= 8'ha5;
    repeat (gap) @(posedge ref_clk);
  endtask

  // Waits out the input synchroniser after each change.
  task automatic arm(input logic v);
    @(posedge ref_clk);
    arm_in <= v;
    repeat (5) @(posedge ref_clk);
  endtask
endmodule // mlts_tgt_model

//--- tb/mlts_seq_tb.sv
/*
  Self-checking bench of the trace sequencer with APB host tasks.
  Assumes the target model file and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps
`include "mlts_regs.vh"
module mlts_seq_tb;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, state_valid, arm_in, trigger_r, break_req_r, irq;
  logic [23:0] state_addr;
  logic [15:0] state_data;
  logic [7:0] state_stat;
  int error_cnt = 0;
  int checks = 0;
  localparam logic [23:0] PA = 24'h001000;
  localparam logic [23:0] PB = 24'h002000;
  localparam logic [23:0] PX = 24'h009000;
  localparam logic [31:0] ANY = 32'h0040_0000;

  always #12.5 ref_clk = ~ref_clk;

  mlts_seq mlts_seq_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .state_valid(state_valid), .state_addr(state_addr), .state_data(state_data),
    .state_stat(state_stat), .arm_in(arm_in), .trigger_r(trigger_r),
    .break_req_r(break_req_r), .irq(irq));

  mlts_tgt_model mlts_tgt_model_i (
    .ref_clk(ref_clk), .break_req_r(break_req_r), .state_valid(state_valid),
    .state_addr(state_addr), .state_data(state_data), .state_stat(state_stat),
    .arm_in(arm_in));

  // ----------------------------------------------------------------------------
  // Host tasks
  // ----------------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic lvl(input logic [2:0] l, input logic [31:0] p, s, t, g);
    logic [11:0] b;
    b = `MLTS_OFS_LVL_BASE + {5'h00, l, 4'h0};
    apb(1'b1, b, p);
    apb(1'b1, b + 12'h004, s);
    apb(1'b1, b + 12'h008, t);
    apb(1'b1, b + 12'h00c, g);
  endtask

  task automatic rdbuf(input logic [31:0] idx, input logic [23:0] a, input logic [15:0] d);
    apb(1'b1, `MLTS_OFS_RD_IDX, idx);
    apb(1'b0, `MLTS_OFS_RD_DATA, 32'h0);
    chk(rd, {a[7:0], d, 8'h5a});
  endtask

  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  task automatic t_seq;
    lvl(3'h0, 32'h1, 32'h3, ANY, 32'h12);
    lvl(3'h2, 32'h1, 32'h2, ANY, 32'h03);
    lvl(3'h3, 32'h0, 32'h0, ANY, 32'h33);
    apb(1'b1, `MLTS_OFS_CTRL, 32'h0000_0309);
    mlts_tgt_model_i.emit(PX, 16'h0101, 0);
    apb(1'b0, `MLTS_OFS_STAT, 32'h0);
    chk(rd & 32'h7, 32'h0);
    mlts_tgt_model_i.emit(PA, 16'h0202, 1);
    apb(1'b0, `MLTS_OFS_STAT, 32'h0);
    chk(rd & 32'h7, 32'h2);
    mlts_tgt_model_i.emit(PB, 16'h0303, 0);
    apb(1'b0, `MLTS_OFS_STAT, 32'h0);
    chk(rd & 32'h7, 32'h0);
    mlts_tgt_model_i.emit(PA, 16'h0404, 0);
    mlts_tgt_model_i.emit(PA, 16'h0505, 0);
    apb(1'b0, `MLTS_OFS_STAT, 32'h0);
    chk(rd & 32'h47, 32'h43);
    chk({31'h0, irq}, 32'h1);
    chk(mlts_tgt_model_i.brk_seen, 32'h1);
    mlts_tgt_model_i.emit(PX, 16'h0606, 2);
    mlts_tgt_model_i.emit(PB, 16'h0707, 0);
    apb(1'b1, `MLTS_OFS_CTRL, 32'h2);
    apb(1'b0, `MLTS_OFS_RD_COUNT, 32'h0);
    chk(rd, 32'h3);
    rdbuf(32'h0, PA, 16'h0505);
    rdbuf(32'h2, PB, 16'h0707);
    apb(1'b1, `MLTS_OFS_IRQ_STAT, 32'h3);
    apb(1'b0, `MLTS_OFS_IRQ_STAT, 32'h0);
    chk(rd & 32'h3, 32'h0);
    chk({31'h0, irq}, 32'h0);
  endtask

  task automatic t_end;
    apb(1'b1, `MLTS_OFS_IRQ_MASK, 32'h0);
    apb(1'b1, `MLTS_OFS_CTRL, 32'h0000_0321);
    apb(1'b0, `MLTS_OFS_RD_COUNT, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, trigger_r}, 32'h0);
    mlts_tgt_model_i.emit(PX, 16'h1111, 0);
    mlts_tgt_model_i.emit(PA, 16'h2222, 0);
    mlts_tgt_model_i.emit(PX, 16'h3333, 0);
    mlts_tgt_model_i.emit(PA, 16'h4444, 0);
    mlts_tgt_model_i.emit(PX, 16'h5555, 0);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, `MLTS_OFS_IRQ_MASK, 32'h3);
    apb(1'b1, `MLTS_OFS_CTRL, 32'h2);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, `MLTS_OFS_RD_COUNT, 32'h0);
    chk(rd, 32'h4);
    rdbuf(32'h3, PA, 16'h4444);
    rdbuf(32'h0, PX, 16'h1111);
    chk(mlts_tgt_model_i.brk_seen, 32'h1);
    apb(1'b1, `MLTS_OFS_IRQ_STAT, 32'h3);
  endtask

  task automatic t_cont;
    lvl(3'h0, 32'h0, 32'h0, 32'h0004_0000, 32'h0);
    apb(1'b1, `MLTS_OFS_PRE_QUAL, ANY);
    apb(1'b1, `MLTS_OFS_CTRL, 32'h45);
    mlts_tgt_model_i.emit(PB, 16'h7777, 0);
    mlts_tgt_model_i.arm(1'b1);
    mlts_tgt_model_i.emit(PX, 16'h8888, 0);
    mlts_tgt_model_i.arm(1'b0);
    mlts_tgt_model_i.emit(PX, 16'h9999, 0);
    apb(1'b0, `MLTS_OFS_STAT, 32'h0);
    chk(rd & 32'hc0, 32'h80);
    apb(1'b1, `MLTS_OFS_CTRL, 32'h2);
    apb(1'b0, `MLTS_OFS_STAT, 32'h0);
    chk(rd & 32'h80, 32'h0);
    apb(1'b0, `MLTS_OFS_RD_COUNT, 32'h0);
    chk(rd, 32'h2);
    apb(1'b0, `MLTS_OFS_COUNT, 32'h0);
    chk(rd, 32'h3);
    rdbuf(32'h0, PB, 16'h7777);
    rdbuf(32'h1, PX, 16'h8888);
  endtask

  // ----------------------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------------------
  task automatic finish_test;
    if (error_cnt == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    finish_test();
  end

  initial begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    apb(1'b0, `MLTS_OFS_CTRL, 32'h0);
    chk(rd, `MLTS_RST_CTRL);
    apb(1'b0, 12'h028, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, `MLTS_OFS_IRQ_MASK, 32'h3);
    apb(1'b1, `MLTS_OFS_PAT_BASE, {8'h00, PA});
    apb(1'b1, `MLTS_OFS_PAT_BASE + 12'h004, {8'h00, PB});
    t_seq();
    t_end();
    t_cont();
    finish_test();
  end
endmodule // mlts_seq_tb
